// file: core/arb_regs.svh
`ifndef ARB_REGS_SVH
`define ARB_REGS_SVH

`define ARB_PTR_RESULT 2'h0
`define ARB_PTR_CTRL 2'h1
`define ARB_PTR_LOWER 2'h2
`define ARB_PTR_UPPER 2'h3

`define ARB_RST_RESULT 16'h0000
`define ARB_RST_CTRL 16'h8583
`define ARB_RST_LOWER 16'h8000
`define ARB_RST_UPPER 16'h7fff
`define ARB_RST_PTR 2'h0

`define ARB_BIT_START 15
`define ARB_BIT_MSB 15

`define ARB_COUNT_ONE 2'h0
`define ARB_COUNT_TWO 2'h1
`define ARB_COUNT_OFF 2'h3
`define ARB_GAIN_MIN 3'h5

`define ARB_SAT_POS 16'h7fff
`define ARB_SAT_NEG 16'h8000

`define ARB_CLK_PERIOD_NS 10
`define ARB_RDY_PULSE_NS 8000
`define ARB_RDY_PULSE_CYC ((`ARB_RDY_PULSE_NS) / (`ARB_CLK_PERIOD_NS))

`endif

// file: core/arb_pkg.sv
package arb_pkg;

  // layout matches the control word bit for bit
  typedef struct packed {
    logic start_done_bit;
    logic [2:0] input_select;
    logic [2:0] gain_range;
    logic single_shot;
    logic [2:0] sample_rate_sel;
    logic window_mode;
    logic alert_polarity;
    logic alert_hold_en;
    logic [1:0] alert_count_sel;
  } arb_ctrl_s;

  // byte-level requests from the serial bus engine
  typedef struct packed {
    logic start;
    logic is_read;
    logic wr_valid;
    logic [7:0] wr_data;
    logic rd_next;
  } arb_bus_s;

  typedef logic signed [17:0] arb_raw_t;

  typedef enum logic {ARB_IDLE, ARB_CONV} arb_conv_e;

  typedef enum logic [1:0] {ARB_WPH_PTR, ARB_WPH_MSB, ARB_WPH_LSB, ARB_WPH_DONE} arb_wph_e;

endpackage

// file: core/arb_alert.sv
`timescale 1ns/10ps
`include "arb_regs.svh"

module arb_alert
  import arb_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_clear,
  input wire arb_ctrl_s i_ctrl,
  input wire logic [15:0] i_lower,
  input wire logic [15:0] i_upper,
  input wire logic i_result_ev,
  input wire logic [15:0] i_result,
  input wire logic i_hold_clear,
  output logic o_alert_oe_n
);

  logic ready_mode;
  logic above;
  logic below;
  logic out_lim;
  logic hit;
  logic active;
  logic asserted;
  logic [2:0] cnt;
  logic [2:0] need;
  logic [9:0] pcnt;

  ////////////////////////////////////////////////////////////////////////////
  assign ready_mode = i_upper[`ARB_BIT_MSB] && !i_lower[`ARB_BIT_MSB] &&
                      i_ctrl.alert_count_sel != `ARB_COUNT_OFF;
  assign above = $signed(i_result) > $signed(i_upper);
  assign below = $signed(i_result) < $signed(i_lower);
  assign out_lim = i_ctrl.window_mode ? (above || below) : above;
  assign need = (i_ctrl.alert_count_sel == `ARB_COUNT_ONE) ? 3'h1 :
                (i_ctrl.alert_count_sel == `ARB_COUNT_TWO) ? 3'h2 : 3'h4;
  assign hit = i_result_ev && out_lim && (cnt + 3'h1 >= need);

  always_ff @(posedge i_core_clk) begin
    if (i_clear) begin
      cnt <= 3'h0;
    end else if (i_result_ev) begin
      cnt <= !out_lim ? 3'h0 : (cnt == 3'h4) ? cnt : cnt + 3'h1;
    end
  end

  // a new hit beats a hold clear in the same cycle
  always_ff @(posedge i_core_clk) begin
    if (i_clear) begin
      active <= 1'b0;
    end else if (hit) begin
      active <= 1'b1;
    end else if (i_ctrl.alert_hold_en) begin
      if (i_hold_clear) begin
        active <= 1'b0;
      end
    end else if (i_result_ev) begin
      if (i_ctrl.window_mode || below) begin
        active <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_clear) begin
      pcnt <= 10'h0;
    end else if (i_result_ev && !i_ctrl.single_shot) begin
      pcnt <= 10'(`ARB_RDY_PULSE_CYC);
    end else if (pcnt != 10'h0) begin
      pcnt <= pcnt - 10'h1;
    end
  end

  assign asserted = ready_mode ? (i_ctrl.single_shot ? i_ctrl.start_done_bit : pcnt != 10'h0) : active;

  // open drain: only the low level is driven
  always_ff @(posedge i_core_clk) begin
    if (i_clear || i_ctrl.alert_count_sel == `ARB_COUNT_OFF) begin
      o_alert_oe_n <= 1'b1;
    end else begin
      o_alert_oe_n <= asserted ? i_ctrl.alert_polarity : !i_ctrl.alert_polarity;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_clear);

  a_float_off: assert property (i_ctrl.alert_count_sel == `ARB_COUNT_OFF |=> o_alert_oe_n)
    else $error("alert pin driven while comparator off");
  a_rdy_pulse: assert property (i_result_ev && !i_ctrl.single_shot |=> pcnt == 10'(`ARB_RDY_PULSE_CYC))
    else $error("ready pulse not loaded");
  a_hold_keep: assert property (active && i_ctrl.alert_hold_en && !i_hold_clear |=> active)
    else $error("held alert dropped without clear");
  c_alert_set: cover property (hit && i_ctrl.window_mode);
endmodule

// file: core/arb_register_bank.sv
`timescale 1ns/10ps
`include "arb_regs.svh"

// Operation
// - result is 16-bit two's complement, left-aligned
// - raw result saturates to 7fff or 8000
// - low two pointer bits select register
// - result read-only, zero until first conversion
// - start bit one starts conversion when down
// - start bit reads zero while converting
// - bits 14:12 select the input pair
// - bits 11:9 select range, high codes clamp
// - bit 8 one single-shot, zero continuous
// - bits 7:5 select output sample rate
// - bit 4 selects window or hysteresis comparator
// - bit 3 sets alert output polarity
// - bit 2 latches an asserted alert
// - bits 1:0 set count or float output
// - results compared against both limit registers
// - upper msb one, lower zero: ready mode
// - ready shows status bit or brief pulse
// - hysteresis or window assert and release behaviour
// - result read or alert response clears latch

module arb_register_bank
  import arb_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_gcall_reset,
  input wire arb_bus_s i_bus,
  input wire logic i_alert_resp,
  input wire logic i_conv_done,
  input wire arb_raw_t i_conv_raw,
  output logic [7:0] o_rd_data,
  output logic o_conv_start,
  output arb_ctrl_s o_conv_cfg,
  output logic [2:0] o_gain_code,
  output logic o_alert_o,
  output logic o_alert_oe_n
);

  logic soft_rst;
  logic [1:0] ptr;
  arb_wph_e wph;
  logic [7:0] wr_msb;
  logic wr_commit;
  logic [15:0] wr_word;
  arb_ctrl_s ctrl;
  logic [15:0] result;
  logic [15:0] lower_limit;
  logic [15:0] upper_limit;
  logic [7:0] rd_lsb;
  logic [15:0] rd_word;
  logic start_done;
  arb_conv_e state;
  arb_conv_e next_state;
  logic start_cmd;
  logic start_now;
  logic done_ev;
  logic [15:0] sat_result;
  logic read_start;
  logic hold_clear;
  arb_ctrl_s ctrl_view;

  ////////////////////////////////////////////////////////////////////////////
  // general call reset acts exactly like the pin reset
  assign soft_rst = !i_resetn || i_gcall_reset;

  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      wph <= ARB_WPH_PTR;
    end else if (i_bus.start) begin
      wph <= ARB_WPH_PTR;
    end else if (i_bus.wr_valid) begin
      case (wph)
        ARB_WPH_PTR: wph <= ARB_WPH_MSB;
        ARB_WPH_MSB: wph <= ARB_WPH_LSB;
        ARB_WPH_LSB: wph <= ARB_WPH_DONE;
        default: wph <= ARB_WPH_DONE;
      endcase
    end
  end

  // upper pointer bits are don't-care on this side
  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      ptr <= `ARB_RST_PTR;
    end else if (i_bus.wr_valid && !i_bus.start && wph == ARB_WPH_PTR) begin
      ptr <= i_bus.wr_data[1:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      wr_msb <= 8'h00;
    end else if (i_bus.wr_valid && !i_bus.start && wph == ARB_WPH_MSB) begin
      wr_msb <= i_bus.wr_data;
    end
  end

  // bytes past the second data byte are dropped
  assign wr_commit = i_bus.wr_valid && !i_bus.start && wph == ARB_WPH_LSB;
  assign wr_word = {wr_msb, i_bus.wr_data};

  ////////////////////////////////////////////////////////////////////////////
  // control word; the start bit lives in start_done instead
  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      ctrl <= arb_ctrl_s'(`ARB_RST_CTRL);
    end else if (wr_commit && ptr == `ARB_PTR_CTRL) begin
      ctrl <= arb_ctrl_s'(wr_word);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      lower_limit <= `ARB_RST_LOWER;
    end else if (wr_commit && ptr == `ARB_PTR_LOWER) begin
      lower_limit <= wr_word;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      upper_limit <= `ARB_RST_UPPER;
    end else if (wr_commit && ptr == `ARB_PTR_UPPER) begin
      upper_limit <= wr_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign start_cmd = wr_commit && ptr == `ARB_PTR_CTRL && wr_word[`ARB_BIT_START];
  assign done_ev = state == ARB_CONV && i_conv_done;

  // writing one while busy is ignored, the running conversion goes on
  always_comb begin
    next_state = state;
    start_now = 1'b0;
    case (state)
      ARB_IDLE: begin
        if (start_cmd || !ctrl.single_shot) begin
          start_now = 1'b1;
          next_state = ARB_CONV;
        end
      end
      ARB_CONV: begin
        if (i_conv_done) begin
          if (ctrl.single_shot) begin
            next_state = ARB_IDLE;
          end else begin
            start_now = 1'b1;
          end
        end
      end
      default: next_state = ARB_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      state <= ARB_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      o_conv_start <= 1'b0;
    end else begin
      o_conv_start <= start_now;
    end
  end

  // settings freeze for the conversion in flight; new ones take the next
  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      o_conv_cfg <= arb_ctrl_s'(`ARB_RST_CTRL);
    end else if (start_now && start_cmd) begin
      // control word lands on this same edge, so take it from the bus
      o_conv_cfg <= arb_ctrl_s'(wr_word);
    end else if (start_now) begin
      o_conv_cfg <= ctrl_view;
    end
  end

  assign o_gain_code = (o_conv_cfg.gain_range > `ARB_GAIN_MIN) ? `ARB_GAIN_MIN : o_conv_cfg.gain_range;

  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      start_done <= 1'b1;
    end else if (start_now) begin
      start_done <= 1'b0;
    end else if (done_ev) begin
      start_done <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    if (i_conv_raw > 18'sh07fff) begin
      sat_result = `ARB_SAT_POS;
    end else if (i_conv_raw < -18'sh08000) begin
      sat_result = `ARB_SAT_NEG;
    end else begin
      sat_result = i_conv_raw[15:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      result <= `ARB_RST_RESULT;
    end else if (done_ev) begin
      result <= sat_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    ctrl_view = ctrl;
    ctrl_view.start_done_bit = start_done;
  end

  always_comb begin
    case (ptr)
      `ARB_PTR_RESULT: rd_word = result;
      `ARB_PTR_CTRL: rd_word = ctrl_view;
      `ARB_PTR_LOWER: rd_word = lower_limit;
      `ARB_PTR_UPPER: rd_word = upper_limit;
      default: rd_word = result;
    endcase
  end

  assign read_start = i_bus.start && i_bus.is_read;

  // word is snapshotted at the read start so both bytes match
  always_ff @(posedge i_core_clk) begin
    if (soft_rst) begin
      o_rd_data <= 8'h00;
      rd_lsb <= 8'h00;
    end else if (read_start) begin
      o_rd_data <= rd_word[15:8];
      rd_lsb <= rd_word[7:0];
    end else if (i_bus.rd_next) begin
      o_rd_data <= rd_lsb;
      rd_lsb <= 8'h00;
    end
  end

  assign hold_clear = i_alert_resp || (read_start && ptr == `ARB_PTR_RESULT);

  ////////////////////////////////////////////////////////////////////////////
  arb_alert u_alert (
    .i_core_clk(i_core_clk),
    .i_clear(soft_rst),
    .i_ctrl(ctrl_view),
    .i_lower(lower_limit),
    .i_upper(upper_limit),
    .i_result_ev(done_ev),
    .i_result(sat_result),
    .i_hold_clear(hold_clear),
    .o_alert_oe_n(o_alert_oe_n)
  );

  assign o_alert_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (soft_rst);

  a_result_zero: assert property (result == 16'h0000 && !done_ev |=> result == 16'h0000)
    else $error("result changed without a conversion");
  a_sat_high: assert property (done_ev && i_conv_raw > 18'sh07fff |=> result == 16'h7fff)
    else $error("positive overrange not saturated");
  a_sat_low: assert property (done_ev && i_conv_raw < -18'sh08000 |=> result == 16'h8000)
    else $error("negative overrange not saturated");
  a_start_single: assert property (state == ARB_IDLE && start_cmd |=> o_conv_start && !start_done)
    else $error("start command did not launch conversion");
  a_start_busy: assert property (state == ARB_CONV && !i_conv_done |=> !o_conv_start)
    else $error("restart while converting");
  a_status_done: assert property (done_ev && ctrl.single_shot |=> start_done && state == ARB_IDLE)
    else $error("status not set after single conversion");
  a_gain_clamp: assert property (o_conv_cfg.gain_range >= 3'h5 |-> o_gain_code == 3'h5)
    else $error("gain code not clamped");
  a_cfg_frozen: assert property (state == ARB_CONV && !o_conv_start && !i_conv_done |=> $stable(o_conv_cfg))
    else $error("settings changed mid conversion");
  a_byte_order: assert property (read_start ##1 i_bus.rd_next |=> o_rd_data == $past(rd_lsb))
    else $error("second read byte wrong");
  a_ptr_low: assert property (i_bus.wr_valid && !i_bus.start && wph == ARB_WPH_PTR |=> ptr == $past(i_bus.wr_data[1:0]))
    else $error("pointer not taken from low bits");

  c_single_shot: cover property (start_cmd ##[1:1000] done_ev);
  c_continuous: cover property (done_ev && !ctrl.single_shot);
  c_read_result: cover property (read_start && ptr == `ARB_PTR_RESULT ##1 i_bus.rd_next);
endmodule

// file: bench/arb_host_model.sv
`timescale 1ns/10ps

module arb_host_model
  import arb_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic [7:0] i_rd_data,
  output arb_bus_s o_bus
);
  initial o_bus = '0;

  // pointer, then msb, then lsb; n=1 gives a pointer-only write
  task automatic wr(input logic [7:0] ptr, input logic [15:0] d, input int n);
    logic [7:0] b [3];
    b = '{ptr, d[15:8], d[7:0]};
    @(posedge i_core_clk);
    o_bus <= '{1'b1, 1'b0, 1'b0, 8'h00, 1'b0};
    for (int i = 0; i < n; i++) begin
      @(posedge i_core_clk);
      o_bus <= '{1'b0, 1'b0, 1'b1, b[i], 1'b0};
    end
    @(posedge i_core_clk);
    // released data bus shows junk, not the last byte
    o_bus <= '{1'b0, 1'b0, 1'b0, ~b[n-1], 1'b0};
  endtask

  task automatic rd(output logic [15:0] d);
    @(posedge i_core_clk);
    o_bus <= '{1'b1, 1'b1, 1'b0, 8'h5a, 1'b0};
    @(posedge i_core_clk);
    o_bus <= '{1'b0, 1'b0, 1'b0, 8'ha5, 1'b1};
    #1 d[15:8] = i_rd_data;
    @(posedge i_core_clk);
    o_bus <= '{1'b0, 1'b0, 1'b0, 8'h3c, 1'b0};
    #1 d[7:0] = i_rd_data;
  endtask
endmodule

// file: bench/arb_register_bank_tb_top.sv
`timescale 1ns/10ps
`include "arb_regs.svh"

module arb_register_bank_tb_top
  import arb_pkg::*;
;
  typedef struct packed {
    logic [7:0] wp;
    logic [15:0] wd;
    logic [7:0] rp;
    logic [15:0] ex;
  } arb_row_s;

  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_gcall_reset = 1'b0;
  logic i_alert_resp = 1'b0;
  logic i_conv_done = 1'b0;
  arb_raw_t i_conv_raw = '0;
  arb_raw_t raw_val = '0;
  arb_bus_s i_bus;
  logic [7:0] o_rd_data;
  logic o_conv_start;
  arb_ctrl_s o_conv_cfg;
  logic [2:0] o_gain_code;
  logic o_alert_o;
  logic o_alert_oe_n;
  logic [15:0] d;
  int cnt = 0;
  int fails = 0;
  int comparisons = 0;
  arb_row_s rows [6] = '{
    '{8'h02, 16'h1234, 8'h02, 16'h1234},
    '{8'h03, 16'h5678, 8'h03, 16'h5678},
    '{8'h00, 16'habcd, 8'h00, 16'h0000},
    '{8'hfe, 16'h4321, 8'h02, 16'h4321},
    '{8'h01, 16'h7ffe, 8'h01, 16'hfffe},
    '{8'h01, 16'h0583, 8'h01, 16'h8583}};
  arb_raw_t raws [5] = '{18'sd0, 18'sd1, -18'sd1, 18'sd40000, -18'sd40000};
  logic [15:0] codes [5] = '{16'h0000, 16'h0001, 16'hffff, 16'h7fff, 16'h8000};

  initial forever #5 i_core_clk = ~i_core_clk;

  arb_register_bank i_dut (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_gcall_reset(i_gcall_reset),
    .i_bus(i_bus),
    .i_alert_resp(i_alert_resp),
    .i_conv_done(i_conv_done),
    .i_conv_raw(i_conv_raw),
    .o_rd_data(o_rd_data),
    .o_conv_start(o_conv_start),
    .o_conv_cfg(o_conv_cfg),
    .o_gain_code(o_gain_code),
    .o_alert_o(o_alert_o),
    .o_alert_oe_n(o_alert_oe_n)
  );

  arb_host_model host (
    .i_core_clk(i_core_clk),
    .i_rd_data(o_rd_data),
    .o_bus(i_bus)
  );

  ////////////////////////////////////////////////////////////////////////
  // modulator stand-in: slow enough that status can be read mid-conversion
  always @(posedge i_core_clk) begin
    i_conv_done <= 1'b0;
    i_conv_raw <= ~raw_val;
    if (o_conv_start) begin
      cnt <= 40;
    end else if (cnt == 1) begin
      i_conv_done <= 1'b1;
      i_conv_raw <= raw_val;
      cnt <= 0;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [7:0] p, output logic [15:0] v);
    host.wr(p, 16'h0000, 1);
    host.rd(v);
  endtask

  task automatic conv(input logic [15:0] c, input arb_raw_t r);
    raw_val = r;
    host.wr(8'h01, c, 3);
    repeat (60) @(posedge i_core_clk);
  endtask

  task automatic oe(input logic e);
    @(posedge i_core_clk);
    #1 chk({15'h0000, o_alert_oe_n}, {15'h0000, e});
  endtask

  task automatic stop_test;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_core_clk);
    fails++;
    stop_test;
  end

  initial begin
    repeat (5) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    foreach (rows[i]) begin
      host.wr(rows[i].wp, rows[i].wd, 3);
      rd(rows[i].rp, d);
      chk(d, rows[i].ex);
    end
    // general-call reset restores every default
    @(posedge i_core_clk);
    i_gcall_reset <= 1'b1;
    @(posedge i_core_clk);
    i_gcall_reset <= 1'b0;
    rd(8'h00, d);
    chk(d, `ARB_RST_RESULT);
    rd(8'h01, d);
    chk(d, `ARB_RST_CTRL);
    rd(8'h02, d);
    chk(d, `ARB_RST_LOWER);
    rd(8'h03, d);
    chk(d, `ARB_RST_UPPER);
    // single shot with top gain code, status low while busy
    raw_val = 18'sd7;
    host.wr(8'h01, 16'h8f83, 3);
    @(posedge i_core_clk);
    #1 chk({13'h0000, o_gain_code}, 16'h0005);
    rd(8'h01, d);
    chk(d & 16'h8000, 16'h0000);
    repeat (50) @(posedge i_core_clk);
    rd(8'h01, d);
    chk(d, 16'h8f83);
    rd(8'h00, d);
    chk(d, 16'h0007);
    foreach (raws[i]) begin
      conv(16'h8583, raws[i]);
      rd(8'h00, d);
      chk(d, codes[i]);
    end
    // traditional comparator, one hit, active low, hysteresis
    host.wr(8'h02, 16'h0100, 3);
    host.wr(8'h03, 16'h0200, 3);
    conv(16'h8180, 18'sh300);
    oe(1'b0);
    conv(16'h8180, 18'sh150);
    oe(1'b0);
    conv(16'h8180, 18'sh050);
    oe(1'b1);
    conv(16'h8180, 18'sh300);
    host.wr(8'h01, 16'h0183, 3);
    oe(1'b1);
    // latched: cleared by result read, then by alert response
    conv(16'h8184, 18'sh300);
    conv(16'h8184, 18'sh050);
    oe(1'b0);
    rd(8'h00, d);
    oe(1'b1);
    conv(16'h8184, 18'sh300);
    conv(16'h8184, 18'sh050);
    i_alert_resp <= 1'b1;
    @(posedge i_core_clk);
    i_alert_resp <= 1'b0;
    oe(1'b1);
    // ready mode follows the status bit in single shot
    host.wr(8'h03, 16'h8000, 3);
    host.wr(8'h02, 16'h0000, 3);
    host.wr(8'h01, 16'h8180, 3);
    repeat (5) @(posedge i_core_clk);
    oe(1'b1);
    repeat (50) @(posedge i_core_clk);
    oe(1'b0);
    // continuous mode: ready pulses keep the pin asserted, status reads busy
    host.wr(8'h01, 16'h0080, 3);
    repeat (100) @(posedge i_core_clk);
    oe(1'b0);
    chk({15'h0000, o_conv_cfg.single_shot}, 16'h0000);
    rd(8'h01, d);
    chk(d & 16'h8000, 16'h0000);
    stop_test;
  end
endmodule
